// ==== src/jtag_decode_regs.svh ====
`ifndef JTAG_DECODE_REGS_SVH
`define JTAG_DECODE_REGS_SVH

`define IR_W 4
`define IDREG_W 32
`define BSR_LEN 16
`define IR_EXTEST 4'h0
`define IR_BYPASS 4'hf
`define IR_IDREAD 4'hb
`define IR_HIGHZ 4'h7
`define IR_CLAMP 4'h4
`define IR_SAMPLE 4'h8
`define IR_LOGIC_RESET 4'hc
`define IR_CAPTURE_PAT 2'h1
// arbitrary identity value, lsb set to mark the register as present
`define IDCODE_VAL 32'h0000_0001

`endif

// ==== src/jtag_decode_pkg.sv ====
package jtag_decode_pkg;
  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SH_DR  = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040, ST_EX2_DR = 16'h0080, ST_UP_DR  = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR  = 16'h2000, ST_EX2_IR = 16'h4000,
    ST_UP_IR  = 16'h8000
  } tap_state_e;
endpackage : jtag_decode_pkg

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  always_comb begin
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // only the second stage leaves this module
  assign q = s_q.sync;
endmodule : pin_sync

// ==== src/jtag_instruction_decode.sv ====
`timescale 1ns/1ps
`include "jtag_decode_regs.svh"

module jtag_instruction_decode
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [`BSR_LEN-1:0] pin_ring_in,
  input wire logic [`BSR_LEN-1:0] core_out,
  input wire logic [`BSR_LEN-1:0] core_oe,
  output logic [`BSR_LEN-1:0] pad_out,
  output logic [`BSR_LEN-1:0] pad_oe,
  output logic core_reset_n,
  output logic [`IR_W-1:0] active_instr,
  output logic [15:0] tap_state
);
  import jtag_decode_pkg::*;

  typedef struct packed {
    tap_state_e st;
    logic tck_d;
    logic [`IR_W-1:0] ir_shift;
    logic [`IR_W-1:0] ir;
    logic skip;
    logic [`IDREG_W-1:0] identity_reg;
    logic [`BSR_LEN-1:0] pin_ring_chain;
    logic [`BSR_LEN-1:0] upd;
    logic tdo;
    logic tdo_oe;
    logic [`BSR_LEN-1:0] pad_out;
    logic [`BSR_LEN-1:0] pad_oe;
    logic core_rst_n;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [2:0] pins;
  logic rise;
  logic fall;
  logic sel_bsr;
  logic sel_id;
  logic so;
  logic sel_skip;
  logic drive_bnd;
  logic float_pads;
  logic hold_core;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  pin_sync #(.W(3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({tck, tms, tdi}),
    .q(pins)
  );

  assign rise = pins[2] & ~s_q.tck_d;
  assign fall = ~pins[2] & s_q.tck_d;

  // ************************************************************
  // instruction decode
  // ************************************************************
  always_comb begin
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    sel_skip = 1'b0;
    drive_bnd = 1'b0;
    float_pads = 1'b0;
    hold_core = 1'b0;
    case (s_q.ir)
      `IR_EXTEST: begin
        sel_bsr = 1'b1;
        drive_bnd = 1'b1;
      end
      `IR_SAMPLE: begin
        sel_bsr = 1'b1;
      end
      `IR_IDREAD: begin
        sel_id = 1'b1;
      end
      `IR_BYPASS: begin
        sel_skip = 1'b1;
      end
      `IR_HIGHZ: begin
        sel_skip = 1'b1;
        float_pads = 1'b1;
      end
      `IR_CLAMP: begin
        sel_skip = 1'b1;
        drive_bnd = 1'b1;
      end
      `IR_LOGIC_RESET: begin
        sel_skip = 1'b1;
        hold_core = 1'b1;
      end
      default: begin
        // reserved codes fall back to the bypass bit, pads stay with the core
        sel_skip = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // tap sequencing and scan registers
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.tck_d = pins[2];
    so = sel_bsr ? s_q.pin_ring_chain[0] : (sel_id ? s_q.identity_reg[0] : s_q.skip);
    if (rise) begin
      case (s_q.st)
        ST_RESET:  s_d.st = pins[1] ? ST_RESET : ST_IDLE;
        ST_IDLE:   s_d.st = pins[1] ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: s_d.st = pins[1] ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: s_d.st = pins[1] ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  s_d.st = pins[1] ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: s_d.st = pins[1] ? ST_UP_DR : ST_PA_DR;
        ST_PA_DR:  s_d.st = pins[1] ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: s_d.st = pins[1] ? ST_UP_DR : ST_SH_DR;
        ST_UP_DR:  s_d.st = pins[1] ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: s_d.st = pins[1] ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: s_d.st = pins[1] ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  s_d.st = pins[1] ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: s_d.st = pins[1] ? ST_UP_IR : ST_PA_IR;
        ST_PA_IR:  s_d.st = pins[1] ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: s_d.st = pins[1] ? ST_UP_IR : ST_SH_IR;
        ST_UP_IR:  s_d.st = pins[1] ? ST_SEL_DR : ST_IDLE;
        default:   s_d.st = ST_RESET;
      endcase
      case (s_q.st)
        ST_CAP_IR: begin
          s_d.ir_shift = {s_q.ir_shift[`IR_W-1:2], `IR_CAPTURE_PAT};
        end
        ST_SH_IR: begin
          s_d.ir_shift = {pins[0], s_q.ir_shift[`IR_W-1:1]};
        end
        ST_UP_IR: begin
          s_d.ir = s_q.ir_shift;
        end
        ST_CAP_DR: begin
          if (sel_skip) begin
            s_d.skip = 1'b0;
          end
          if (sel_bsr) begin
            s_d.pin_ring_chain = pin_ring_in;
          end
          if (sel_id) begin
            s_d.identity_reg = `IDCODE_VAL;
          end
        end
        ST_SH_DR: begin
          s_d.skip = pins[0];
          if (sel_bsr) begin
            s_d.pin_ring_chain = {pins[0], s_q.pin_ring_chain[`BSR_LEN-1:1]};
          end
          if (sel_id) begin
            s_d.identity_reg = {pins[0], s_q.identity_reg[`IDREG_W-1:1]};
          end
        end
        ST_UP_DR: begin
          if (sel_bsr) begin
            s_d.upd = s_q.pin_ring_chain;
          end
        end
        default: begin
        end
      endcase
    end
    // test-logic-reset holds the identity-read code from the first clock on
    if (s_q.st == ST_RESET) begin
      s_d.ir = `IR_IDREAD;
    end
    if (fall) begin
      s_d.tdo_oe = (s_q.st == ST_SH_DR) || (s_q.st == ST_SH_IR);
      s_d.tdo = (s_q.st == ST_SH_IR) ? s_q.ir_shift[0] : so;
    end
    // output path: pass-through, boundary drive or float
    if (float_pads) begin
      s_d.pad_out = core_out;
      s_d.pad_oe = '0;
    end else if (drive_bnd) begin
      s_d.pad_out = s_q.upd;
      s_d.pad_oe = '1;
    end else begin
      s_d.pad_out = core_out;
      s_d.pad_oe = core_oe;
    end
    s_d.core_rst_n = !hold_core;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: ST_RESET, ir: `IR_IDREAD, core_rst_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tdo = s_q.tdo;
  assign tdo_oe = s_q.tdo_oe;
  assign pad_out = s_q.pad_out;
  assign pad_oe = s_q.pad_oe;
  assign core_reset_n = s_q.core_rst_n;
  assign active_instr = s_q.ir;
  assign tap_state = s_q.st;
endmodule : jtag_instruction_decode

// ==== test/tap_host.sv ====
`timescale 1ns/1ps
module tap_host (
  input wire logic clk,
  input wire logic tdo,
  output logic tck = 1'b0,
  output logic tms = 1'b0,
  output logic tdi = 1'b0
);
  task step(input logic m, d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask : step
  task scan(input logic ir, int n, logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    repeat (2) step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : tap_host

// ==== test/tap_chk_sva.sv ====
`timescale 1ns/1ps
module tap_chk
  import jtag_decode_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tdo_oe,
  input wire logic [15:0] pad_oe,
  input wire logic core_reset_n,
  input wire logic [3:0] active_instr,
  input wire logic [15:0] tap_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_held(logic [3:0] c);
    (active_instr == c) [*2];
  endsequence
  a_pads_float: assert property (s_held(4'h7) |-> pad_oe == '0) else $error("float");
  a_core_hold: assert property (s_held(4'hc) |-> !core_reset_n) else $error("hold");
  a_core_free: assert property ((active_instr != 4'hc) [*2] |-> core_reset_n)
    else $error("free");
  a_reset_cause: assert property ($fell(core_reset_n) |-> $past(active_instr) == 4'hc)
    else $error("cause");
  a_reset_id: assert property ((tap_state == ST_RESET) [*2] |-> active_instr == 4'hb)
    else $error("idread");
  a_state_onehot: assert property ($onehot(tap_state)) else $error("onehot");
  a_instr_update: assert property ($changed(active_instr) |->
    $past(tap_state) inside {ST_UP_IR, ST_RESET} || tap_state == ST_RESET) else $error("update");
  a_drive_shift: assert property ($rose(tdo_oe) |-> tap_state inside {ST_SH_DR, ST_SH_IR})
    else $error("shift");
endmodule : tap_chk

bind jtag_instruction_decode tap_chk u_tap_chk (.*);

// ==== test/jtag_instruction_decode_test.sv ====
`timescale 1ns/1ps
`include "jtag_decode_regs.svh"
module jtag_instruction_decode_test;
  logic clk = 1'b0, resetn = 1'b0, tdo, tdo_oe, tck, tms, tdi, core_reset_n, q;
  logic [15:0] pin_ring_in = 16'ha5c3, core_out = 16'h3c96, pad_out, pad_oe, tap_state;
  logic [3:0] active_instr;
  logic [31:0] got;
  int fails = 0, checks = 0;
  always #5 clk = ~clk;
  jtag_instruction_decode u_jtag_instruction_decode (.*, .core_oe(pin_ring_in));
  tap_host u_tap_host (.*);
  task chk(input logic [31:0] s, e);
    checks++;
    fails += (s !== e);
    if (s !== e) $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
  endtask : chk
  task wrap_up;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic t_codes;
    logic [3:0] c [6] = '{4'h8, 4'h0, 4'hf, 4'h7, 4'hc, 4'h4};
    foreach (c[i]) begin
      u_tap_host.scan(1'b1, 4, {28'h0, c[i]}, got);
      chk(got[1:0], 2'h1);
      chk(active_instr, c[i]);
      u_tap_host.scan(1'b0, i < 2 ? 16 : 4, 32'h123d, got);
      chk(got, i < 2 ? pin_ring_in : 32'ha);
      chk(core_reset_n, c[i] != 4'hc);
      if (c[i] inside {4'h0, 4'h4, 4'hf}) chk(pad_out, c[i][0] ? core_out : 16'h123d);
      if (c[i] == 4'h7) chk(pad_oe, 16'h0);
      if (c[i] inside {4'h0, 4'h4}) chk(pad_oe, 16'hffff);
      if (c[i] inside {4'h8, 4'hf, 4'hc}) chk(pad_oe, pin_ring_in);
    end
  endtask : t_codes
  task t_reset_id;
    repeat (5) u_tap_host.step(1'b1, 1'b0, q);
    chk(tap_state, jtag_decode_pkg::ST_RESET);
    chk(active_instr, `IR_IDREAD);
    u_tap_host.step(1'b0, 1'b0, q);
    u_tap_host.scan(1'b0, 32, 32'h0, got);
    chk(got, `IDCODE_VAL);
    chk(tdo_oe, 1'b0);
    chk(tap_state, jtag_decode_pkg::ST_IDLE);
  endtask : t_reset_id
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(active_instr, `IR_IDREAD);
    u_tap_host.step(1'b0, 1'b0, q);
    t_codes();
    t_reset_id();
    wrap_up();
  end
endmodule : jtag_instruction_decode_test
